// [rtl/status_enable_handler.sv]
// status clear, standard event enable write and read handler
`timescale 1ns/1ps
// Summary of operation
// - clear-status clears all event registers, summaries
// - clear-status keeps queue, enables, message flag
// - enable-write loads 0..255 into mask
// - mask bits 7..0 map standard events
// - mask zero at power-up and key reset
// - out-of-range write raises execution error
// - enable-read returns mask, header if enabled
// - only the query error suppresses the query response
// - response over 2000 bytes flags query error
// - volatile settings restored at power-up
// - defaults: headers off, separator 0, terminator 1
module status_enable_handler (
	input  wire logic                       clk_in,
	input  wire logic                       reset_n_in,
	input  wire logic                       key_reset_in,
	input  wire status_pkg::command_t       command_in,
	input  wire logic                       command_valid_in,
	input  wire logic [15:0]                argument_in,
	input  wire logic [15:0]                response_length_in,
	input  wire logic [7:0]                 event_set_in,
	input  wire logic [7:0]                 event_register_zero_set_in,
	input  wire logic [7:0]                 event_register_one_set_in,
	input  wire logic [7:0]                 event_register_two_set_in,
	input  wire logic [7:0]                 frequency_event_register_set_in,
	input  wire logic                       message_available_flag_in,
	output logic [7:0]                      standard_event_enable_mask_out,
	output logic [7:0]                      standard_event_out,
	output logic [7:0]                      event_register_zero_out,
	output logic [7:0]                      event_register_one_out,
	output logic [7:0]                      event_register_two_out,
	output logic [7:0]                      frequency_event_register_out,
	output logic [7:0]                      status_byte_out,
	output logic                            response_valid_out,
	output logic                            response_header_out,
	output logic [3:0]                      response_hundreds_out,
	output logic [3:0]                      response_tens_out,
	output logic [3:0]                      response_ones_out,
	output logic                            header_setting_out,
	output logic                            serial_answer_setting_out,
	output logic [1:0]                      field_separator_setting_out,
	output logic [1:0]                      line_terminator_setting_out,
	output logic                            column_format_out
);
	logic [7:0] mask_reg, ser_reg, zero_event_reg, one_event_reg, two_event_reg, freq_event_reg;
	logic       key_meta_reg, key_sync_reg;
	logic       resp_valid_reg;
	logic [3:0] hund_reg, tens_reg, ones_reg;
	logic       in_range;
	logic [7:0] dec_mask;
	logic [3:0] dec_h, dec_t, dec_o;
	logic       do_clear, do_write, do_read, write_bad, read_too_long;
	logic [7:0] ser_errors;
	logic       esb;

	enable_decoder u_dec (
		.value_in     (do_read ? {8'h00, mask_reg} : argument_in),
		.in_range_out (in_range),
		.mask_out     (dec_mask),
		.hundreds_out (dec_h),
		.tens_out     (dec_t),
		.ones_out     (dec_o)
	);

	assign do_clear      = command_valid_in && command_in == status_pkg::CMD_CLEAR_STATUS;
	assign do_write      = command_valid_in && command_in == status_pkg::CMD_ENABLE_WRITE;
	assign do_read       = command_valid_in && command_in == status_pkg::CMD_ENABLE_READ;
	assign write_bad     = do_write && !in_range;
	assign read_too_long = do_read && response_length_in > 16'(status_pkg::RESPONSE_MAX_BYTES);
	assign ser_errors    = (8'(write_bad) << status_pkg::SER_EXE_BIT)
		| (8'(read_too_long) << status_pkg::SER_QYE_BIT);
	assign esb           = |(ser_reg & mask_reg);

	// key reset comes from a panel pin, two flops first
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			key_meta_reg <= 1'b0;
			key_sync_reg <= 1'b0;
		end else begin
			key_meta_reg <= key_reset_in;
			key_sync_reg <= key_meta_reg;
		end
	end

	// mask, cleared by power-up and key reset only
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in)
			mask_reg <= status_pkg::ENABLE_RESET;
		else if (key_sync_reg)
			mask_reg <= status_pkg::ENABLE_RESET;
		else if (do_write && in_range)
			mask_reg <= dec_mask;
	end

	// event registers; set wins over clear
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ser_reg  <= 8'h00;
			zero_event_reg <= 8'h00;
			one_event_reg  <= 8'h00;
			two_event_reg  <= 8'h00;
			freq_event_reg <= 8'h00;
		end else begin
			ser_reg        <= (do_clear ? 8'h00 : ser_reg) | event_set_in | ser_errors;
			zero_event_reg <= (do_clear ? 8'h00 : zero_event_reg) | event_register_zero_set_in;
			one_event_reg  <= (do_clear ? 8'h00 : one_event_reg) | event_register_one_set_in;
			two_event_reg  <= (do_clear ? 8'h00 : two_event_reg) | event_register_two_set_in;
			freq_event_reg <= (do_clear ? 8'h00 : freq_event_reg) | frequency_event_register_set_in;
		end
	end

	// query response, none on error
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			resp_valid_reg <= 1'b0;
			hund_reg       <= 4'h0;
			tens_reg       <= 4'h0;
			ones_reg       <= 4'h0;
		end else begin
			resp_valid_reg <= do_read && !read_too_long;
			if (do_read) begin
				hund_reg <= dec_h;
				tens_reg <= dec_t;
				ones_reg <= dec_o;
			end
		end
	end

	assign standard_event_enable_mask_out = mask_reg;
	assign standard_event_out             = ser_reg;
	assign event_register_zero_out        = zero_event_reg;
	assign event_register_one_out         = one_event_reg;
	assign event_register_two_out         = two_event_reg;
	assign frequency_event_register_out   = freq_event_reg;
	// summary bits follow the registers; message flag passes through
	assign status_byte_out = (8'(|zero_event_reg) << status_pkg::STB_ZERO_BIT)
		| (8'(|one_event_reg | |freq_event_reg) << status_pkg::STB_ONE_BIT)
		| (8'(|two_event_reg) << status_pkg::STB_TWO_BIT)
		| (8'(message_available_flag_in) << status_pkg::STB_MSG_BIT)
		| (8'(esb) << status_pkg::STB_ESB_BIT);
	assign response_valid_out    = resp_valid_reg;
	assign response_header_out   = header_setting_out;
	assign response_hundreds_out = hund_reg;
	assign response_tens_out     = tens_reg;
	assign response_ones_out     = ones_reg;
	// volatile settings fixed at their defaults
	assign header_setting_out          = status_pkg::HEADER_RESET;
	assign serial_answer_setting_out   = status_pkg::ANSWER_RESET;
	assign field_separator_setting_out = status_pkg::SEPARATOR_RESET;
	assign line_terminator_setting_out = status_pkg::TERMINATOR_RESET;
	assign column_format_out           = status_pkg::COLUMN_RESET;

	// named steps of the checked behaviours
	sequence write_ok_s;
		do_write && in_range && !key_sync_reg;
	endsequence
	sequence read_ok_s;
		do_read && !read_too_long;
	endsequence
	sequence quiet_clear_s;
		do_clear && event_set_in == 8'h00 && ser_errors == 8'h00
		&& event_register_zero_set_in == 8'h00 && event_register_one_set_in == 8'h00
		&& event_register_two_set_in == 8'h00 && frequency_event_register_set_in == 8'h00;
	endsequence

	mask_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		write_ok_s |=> mask_reg == $past(argument_in[7:0]))
		else $error("mask not loaded");
	mask_hold_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!do_write && !key_sync_reg |=> $stable(mask_reg))
		else $error("mask changed unasked");
	bad_write_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		write_bad && !key_sync_reg |=> $stable(mask_reg) && ser_reg[status_pkg::SER_EXE_BIT])
		else $error("bad write accepted");
	key_reset_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		key_sync_reg |=> mask_reg == 8'h00)
		else $error("key reset missed");
	clear_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		quiet_clear_s |=> ser_reg == 8'h00 && zero_event_reg == 8'h00)
		else $error("clear missed");
	clear_rest_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		quiet_clear_s |=> one_event_reg == 8'h00 && two_event_reg == 8'h00 && freq_event_reg == 8'h00)
		else $error("clear missed a register");
	clear_summary_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		quiet_clear_s |=> status_byte_out[2:0] == 3'h0 && !status_byte_out[status_pkg::STB_ESB_BIT])
		else $error("summary not cleared");
	set_wins_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		event_register_zero_set_in != 8'h00
		|=> (zero_event_reg & $past(event_register_zero_set_in)) == $past(event_register_zero_set_in))
		else $error("event set lost");
	clear_keeps_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		do_clear && !key_sync_reg |=> $stable(mask_reg))
		else $error("clear changed mask");
	msg_keep_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		do_clear |=> status_byte_out[status_pkg::STB_MSG_BIT] == message_available_flag_in)
		else $error("clear changed message flag");
	idle_resp_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		!do_read |=> !response_valid_out)
		else $error("response without query");
	read_resp_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		read_ok_s |=> response_valid_out
		&& 8'(response_hundreds_out * 100 + response_tens_out * 10 + response_ones_out) == $past(mask_reg))
		else $error("bad read response");
	no_resp_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		read_too_long |=> !response_valid_out && ser_reg[status_pkg::SER_QYE_BIT])
		else $error("response on error");
	summary_a: assert property (@(posedge clk_in) disable iff (!reset_n_in)
		status_byte_out[status_pkg::STB_ESB_BIT] == |(ser_reg & mask_reg))
		else $error("summary wrong");
endmodule : status_enable_handler

// [include/status_pkg.sv]
// constants for the status and enable command handler
package status_pkg;
	localparam int          ENABLE_WIDTH      = 8;
	localparam logic [7:0]  ENABLE_RESET      = 8'h00;
	localparam int          ENABLE_MAX        = 255;
	localparam int          RESPONSE_MAX_BYTES = 2000;
	localparam int          STB_MSG_BIT       = 4;
	localparam int          STB_ESB_BIT       = 5;
	localparam int          STB_ZERO_BIT      = 0;
	localparam int          STB_ONE_BIT       = 1;
	localparam int          STB_TWO_BIT       = 2;
	localparam int          SER_EXE_BIT       = 4;
	localparam int          SER_QYE_BIT       = 2;
	localparam logic        HEADER_RESET      = 1'b0;
	localparam logic        ANSWER_RESET      = 1'b0;
	localparam logic [1:0]  SEPARATOR_RESET   = 2'h0;
	localparam logic [1:0]  TERMINATOR_RESET  = 2'h1;
	localparam logic        COLUMN_RESET      = 1'b0;
	typedef enum logic [2:0] {
		CMD_NONE, CMD_CLEAR_STATUS, CMD_ENABLE_WRITE, CMD_ENABLE_READ, CMD_OTHER
	} command_t;
endpackage : status_pkg

// [rtl/enable_decoder.sv]
// range check and decimal digit split of the enable value
`timescale 1ns/1ps
module enable_decoder (
	input  wire logic [15:0] value_in,
	output logic             in_range_out,
	output logic [7:0]       mask_out,
	output logic [3:0]       hundreds_out,
	output logic [3:0]       tens_out,
	output logic [3:0]       ones_out
);
	logic [7:0] v;
	assign in_range_out = value_in <= 16'(status_pkg::ENABLE_MAX);
	assign mask_out     = value_in[7:0];
	assign v            = value_in[7:0];
	assign hundreds_out = 4'(v / 8'd100);
	assign tens_out     = 4'((v % 8'd100) / 8'd10);
	assign ones_out     = 4'(v % 8'd10);
endmodule : enable_decoder

// [verification/host_model.sv]
// host controller model issuing commands to the handler
`timescale 1ns/1ps
module host_model (
	input  wire logic           clk_in,
	output status_pkg::command_t command_out,
	output logic                command_valid_out,
	output logic [15:0]         argument_out,
	output logic [15:0]         response_length_out
);
	initial begin
		command_out = status_pkg::CMD_NONE;
		command_valid_out = 1'b0;
		argument_out = 16'h0000;
		response_length_out = 16'h0000;
	end
	// one-cycle command pulse launched at a falling edge
	task automatic issue(input status_pkg::command_t c, input logic [15:0] a, input logic [15:0] l);
		@(negedge clk_in);
		command_out = c;
		command_valid_out = 1'b1;
		argument_out = a;
		response_length_out = l;
		@(negedge clk_in);
		command_valid_out = 1'b0;
		command_out = status_pkg::CMD_NONE;
		argument_out = ~a;
	endtask : issue
endmodule : host_model

// [verification/tb_status_enable_command_handler.sv]
// self-checking bench for the status and enable command handler
`timescale 1ns/1ps
module tb_status_enable_command_handler;
	logic                 clk_in, reset_n_in, key_reset_in, message_available_flag, cv, rv, rh, hs, sa, cf;
	status_pkg::command_t cmd;
	logic [15:0]          arg, len;
	logic [7:0]           e [5];
	logic [7:0]           s [5];
	logic [7:0]           mask, ser, e0, e1, e2, ef, stb, v;
	logic [3:0]           dh, dt, d1;
	logic [1:0]           fs, lt;
	integer               n_errors = 0, n_compared = 0, seed = 32'h2d969361, cyc = 0, i;
	host_model host_model_i (.clk_in(clk_in), .command_out(cmd), .command_valid_out(cv),
		.argument_out(arg), .response_length_out(len));
	status_enable_handler status_enable_handler_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.key_reset_in(key_reset_in), .command_in(cmd), .command_valid_in(cv), .argument_in(arg),
		.response_length_in(len), .event_set_in(e[0]), .event_register_zero_set_in(e[1]),
		.event_register_one_set_in(e[2]), .event_register_two_set_in(e[3]),
		.frequency_event_register_set_in(e[4]), .message_available_flag_in(message_available_flag),
		.standard_event_enable_mask_out(mask), .standard_event_out(ser), .event_register_zero_out(e0),
		.event_register_one_out(e1), .event_register_two_out(e2), .frequency_event_register_out(ef),
		.status_byte_out(stb), .response_valid_out(rv), .response_header_out(rh),
		.response_hundreds_out(dh), .response_tens_out(dt), .response_ones_out(d1),
		.header_setting_out(hs), .serial_answer_setting_out(sa), .field_separator_setting_out(fs),
		.line_terminator_setting_out(lt), .column_format_out(cf));
	function automatic logic [11:0] dec(input logic [7:0] x);
		return {4'(x / 100), 4'((x / 10) % 10), 4'(x % 10)};
	endfunction : dec
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic report_and_stop;
		$display("compared=%0d errors=%0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			report_and_stop();
		end
	end
	initial begin
		reset_n_in = 1'b0;
		key_reset_in = 1'b0;
		message_available_flag = 1'b0;
		for (i = 0; i < 5; i++) e[i] = 8'h00;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		reset_n_in = 1'b1;
		chk(mask, 16'h0000);
		chk({hs, sa, fs, lt, cf, rh}, 16'h0004);
		$display("test defaults done");
		for (i = 0; i < 20; i++) begin
			v = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
			host_model_i.issue(status_pkg::CMD_ENABLE_WRITE, {8'h00, v}, 16'h0000);
			chk(mask, v);
			host_model_i.issue(status_pkg::CMD_ENABLE_READ, 16'h0000, 16'h07D0);
			chk(rv, 1'b1);
			chk({dh, dt, d1}, dec(v));
		end
		$display("test write and read done");
		host_model_i.issue(status_pkg::CMD_ENABLE_WRITE, 16'h0100 | 16'($random(seed)), 16'h0000);
		chk({mask, 3'h0, ser[4]}, {v, 4'h1});
		host_model_i.issue(status_pkg::CMD_ENABLE_READ, 16'h0000, 16'h07D1);
		chk({rv, ser[2]}, 2'h1);
		host_model_i.issue(status_pkg::CMD_ENABLE_WRITE, 16'h0000, 16'h0000);
		chk(stb[5], 1'b0);
		host_model_i.issue(status_pkg::CMD_ENABLE_WRITE, 16'h0010, 16'h0000);
		chk(stb[5], 1'b1);
		$display("test errors and summary done");
		message_available_flag = 1'b1;
		for (i = 0; i < 5; i++) begin
			s[i] = 8'($random(seed)) | 8'h02;
			e[i] = s[i];
		end
		@(negedge clk_in);
		for (i = 0; i < 5; i++) e[i] = 8'h00;
		chk(e0, s[1]);
		chk({e1, e2}, {s[2], s[3]});
		chk({ef, 5'h00, stb[2:0]}, {s[4], 8'h07});
		host_model_i.issue(status_pkg::CMD_CLEAR_STATUS, 16'h0000, 16'h0000);
		chk({ser, e0}, 16'h0000);
		chk({e1, e2}, 16'h0000);
		chk({ef, stb & 8'h27}, 16'h0000);
		chk({mask, stb}, 16'h1010);
		$display("test clear status done");
		@(negedge clk_in);
		key_reset_in = 1'b1;
		@(negedge clk_in);
		key_reset_in = 1'b0;
		repeat (2) @(negedge clk_in);
		chk(mask, 16'h0000);
		$display("test key reset done");
		report_and_stop();
	end
endmodule : tb_status_enable_command_handler
